// ===== src/electronic_gearbox.sv
// electronic gearbox top: links base demand to master encoder movement
// Overview of operation
// R1: linked base demand follows master movement times ratio
// R2: ratio counts base edges per master edge
// R3: ratio signed, sixteen fractional bits
// R4: same-master link request updates target ratio
// R5: other-master link request ignored while linked
// R6: cancel or fast halt ends link
// R7: effective ratio slews at ratio_slew_rate
// R8: ratio_slew_rate resets to 1000000 per second
// R9: request uses default axis unless overridden
// R10: cancel stops link instantly, no ramp
// R11: fractional remainder kept, no drift
module electronic_gearbox (
    input wire logic clk,
    input wire logic rst,
    // request strobes
    input wire logic link_req,
    input wire logic [gearbox_pkg::RATIO_W-1:0] link_ratio,
    input wire logic [gearbox_pkg::AXIS_W-1:0] link_master,
    input wire logic cancel_req,
    input wire logic fast_halt_request,
    input wire logic axis_override,
    input wire logic [gearbox_pkg::AXIS_W-1:0] override_axis,
    // configuration
    input wire logic [gearbox_pkg::AXIS_W-1:0] base_axis_sel,
    input wire logic rate_wr,
    input wire logic [gearbox_pkg::RATE_W-1:0] rate_wdata,
    // per-axis encoder edge steps, one signed word per axis, packed
    input wire logic [gearbox_pkg::NUM_AXES*gearbox_pkg::DELTA_W-1:0] enc_delta,
    // status and outputs
    output logic linked,
    output logic [gearbox_pkg::AXIS_W-1:0] master_axis,
    output logic [gearbox_pkg::RATIO_W-1:0] target_ratio,
    output logic [gearbox_pkg::RATIO_W-1:0] eff_ratio,
    output logic [gearbox_pkg::RATE_W-1:0] ratio_slew_rate,
    output logic [gearbox_pkg::POS_W-1:0] demand_pos,
    output logic servo_tick
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    gearbox_pkg::link_state_t state_q; // link state
    logic [gearbox_pkg::AXIS_W-1:0] master_q; // linked master axis
    logic [gearbox_pkg::RATIO_W-1:0] target_q; // requested ratio
    logic [gearbox_pkg::RATE_W-1:0] rate_q; // slew rate in ratio/s
    logic [gearbox_pkg::RATIO_W-1:0] step_q; // ratio step per tick, 16.16
    logic [47:0] step_wide; // unsaturated step per tick
    logic [15:0] tick_cnt_q; // servo tick divider
    logic tick_q; // one-cycle servo tick
    logic signed [gearbox_pkg::ACC_W-1:0] acc_q; // position in 16.16 edges
    logic [gearbox_pkg::AXIS_W-1:0] req_axis; // axis addressed by request
    logic for_us; // request targets this axis
    logic accept_new; // link request starting a link
    logic accept_upd; // link request updating ratio
    logic stop_now; // link end this cycle
    logic signed [gearbox_pkg::DELTA_W-1:0] mdelta; // selected master step
    logic signed [gearbox_pkg::ACC_W-1:0] incr; // scaled increment

    // slicing the packed encoder bus
    function automatic logic signed [gearbox_pkg::DELTA_W-1:0] pick_delta(
        input logic [gearbox_pkg::NUM_AXES*gearbox_pkg::DELTA_W-1:0] bus,
        input logic [gearbox_pkg::AXIS_W-1:0] ax
    );
        pick_delta = bus[ax*gearbox_pkg::DELTA_W +: gearbox_pkg::DELTA_W];
    endfunction

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------
    // one-off override wins over the default base selection
    assign req_axis = axis_override ? override_axis : base_axis_sel; // [R9]
    assign for_us = (req_axis == gearbox_pkg::OWN_AXIS); // [R9]
    // cancel and fast halt win over a link request in the same cycle
    assign stop_now = for_us && (cancel_req || fast_halt_request); // [R6]
    assign accept_new = for_us && link_req && !stop_now
                      && (state_q == gearbox_pkg::ST_IDLE);
    // a different master while linked is dropped silently
    assign accept_upd = for_us && link_req && !stop_now
                      && (state_q == gearbox_pkg::ST_LINKED)
                      && (link_master == master_q); // [R4] [R5]

    // ---------------------------------------------------------------
    // servo tick divider
    // ---------------------------------------------------------------
    // all motion updates except the stop clear of eff_ratio happen on this enable, not every clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 16'(gearbox_pkg::TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // link state machine
    // ---------------------------------------------------------------
    // no ramp on stop: a link is not a profiled move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= gearbox_pkg::ST_IDLE;
        end else begin
            case (state_q)
                gearbox_pkg::ST_IDLE: begin
                    if (accept_new) begin
                        state_q <= gearbox_pkg::ST_LINKED;
                    end
                end
                gearbox_pkg::ST_LINKED: begin
                    if (stop_now) begin
                        state_q <= gearbox_pkg::ST_IDLE; // [R6] [R10]
                    end
                end
                default: begin
                    state_q <= gearbox_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // master and target ratio capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_q <= '0;
            target_q <= '0;
        end else if (accept_new) begin
            master_q <= link_master;
            target_q <= link_ratio; // [R3]
        end else if (accept_upd) begin
            target_q <= link_ratio; // [R4]
        end
    end

    // ---------------------------------------------------------------
    // slew rate setting
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_q <= gearbox_pkg::SLEW_RATE_RST; // [R8]
        end else if (rate_wr) begin
            rate_q <= rate_wdata;
        end
    end

    // per-tick step in 16.16: rate << 16 / ticks per second, saturated
    // division is static so it synthesises to a constant divider
    assign step_wide = {rate_q, 16'h0000} / 48'(gearbox_pkg::TICKS_PER_S);

    // registered so the divider is off the slewer's path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_q <= '0;
        end else if (step_wide[47:31] != '0) begin
            step_q <= 32'h7FFFFFFF; // beyond any ratio: jump at once
        end else begin
            step_q <= step_wide[31:0]; // [R7]
        end
    end

    // ---------------------------------------------------------------
    // effective ratio
    // ---------------------------------------------------------------
    ratio_slewer u_slew (
        .clk(clk),
        .rst(rst),
        .tick(tick_q),
        .clear(stop_now && state_q == gearbox_pkg::ST_LINKED), // [R10]
        .load(1'b0),
        .target(state_q == gearbox_pkg::ST_LINKED ? target_q : '0),
        .step(step_q),
        .ratio(eff_ratio)
    );

    // ---------------------------------------------------------------
    // position follower
    // ---------------------------------------------------------------
    // raw edges times 16.16 ratio gives 16.16 base edges
    assign mdelta = pick_delta(enc_delta, master_q); // [R2]
    // both operands sign-extended first so the product is formed at full width
    assign incr = $signed({{48{mdelta[15]}}, mdelta})
                * $signed({{32{eff_ratio[31]}}, eff_ratio}); // [R1] [R2]

    // whole accumulator kept, fraction never dropped so no long-run drift
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else if (tick_q && state_q == gearbox_pkg::ST_LINKED && !stop_now) begin
            acc_q <= acc_q + incr; // [R1] [R11]
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign linked = (state_q == gearbox_pkg::ST_LINKED);
    assign master_axis = master_q;
    assign target_ratio = target_q;
    assign ratio_slew_rate = rate_q;
    assign demand_pos = acc_q[gearbox_pkg::FRAC_W +: gearbox_pkg::POS_W]; // integer edges
    assign servo_tick = tick_q;
endmodule // electronic_gearbox

// ===== shared/gearbox_pkg.sv
// constants and types shared by the electronic gearbox design
package gearbox_pkg;
    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int AXIS_W = 2;               // axis number width
    localparam int NUM_AXES = 4;             // axes served
    localparam int RATIO_W = 32;             // signed ratio width
    localparam int FRAC_W = 16;              // fractional bits of ratio
    localparam int DELTA_W = 16;             // signed encoder edge step per tick
    localparam int POS_W = 32;               // demand position width
    localparam int ACC_W = 64;               // position accumulator width
    localparam int RATE_W = 32;              // slew rate integer ratio/s
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 125000000;       // system clock
    localparam int TICK_US = 50;             // servo tick period in us, short enough to test
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US; // cycles per tick
    localparam int TICKS_PER_S = 1000000 / TICK_US;          // ticks per second
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [RATE_W-1:0] SLEW_RATE_RST = 32'h000F4240; // 1000000 ratio/s
    localparam logic [AXIS_W-1:0] BASE_AXIS_RST = 2'h0;         // default base axis
    localparam logic [AXIS_W-1:0] OWN_AXIS = 2'h0;              // axis this block drives
    // link states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LINKED = 2'b10
    } link_state_t;
endpackage : gearbox_pkg

// ===== src/ratio_slewer.sv
// ratio slewer: moves the effective ratio toward the target at a limited rate
module ratio_slewer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic clear,
    input wire logic load,
    input wire logic [gearbox_pkg::RATIO_W-1:0] target,
    input wire logic [gearbox_pkg::RATIO_W-1:0] step,
    output logic [gearbox_pkg::RATIO_W-1:0] ratio
);
    // ---------------------------------------------------------------
    // slew state
    // ---------------------------------------------------------------
    logic signed [gearbox_pkg::RATIO_W:0] diff; // target minus ratio, one guard bit
    logic signed [gearbox_pkg::RATIO_W:0] stp;  // step widened

    assign diff = $signed({target[gearbox_pkg::RATIO_W-1], target})
                - $signed({ratio[gearbox_pkg::RATIO_W-1], ratio});
    assign stp = $signed({1'b0, step});

    // clamp step to remaining distance so the ratio never overshoots
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ratio <= '0;
        end else if (clear) begin
            ratio <= '0;                        // link ended: no drive
        end else if (load) begin
            ratio <= target;                    // load takes target at once; the top ties load low, so a first link slews from zero
        end else if (tick) begin
            if (diff > stp) begin
                ratio <= ratio + step;          // [R7]
            end else if (diff < -stp) begin
                ratio <= ratio - step;          // [R7]
            end else begin
                ratio <= target;
            end
        end
    end
endmodule // ratio_slewer

// ===== verification/encoder_model.sv
// partner model: driving-axis encoder channels feeding edge steps
module encoder_model (
    output logic [gearbox_pkg::NUM_AXES*gearbox_pkg::DELTA_W-1:0] enc_delta
);
    timeunit 1ns;
    timeprecision 1ps;
    // fixed steps per tick; distinct per axis so a wrong master shows up
    assign enc_delta = {16'h00C8, 16'h0064, 16'h0006, 16'h0032};
endmodule // encoder_model

// ===== verification/electronic_gearbox_chk.sv
// port checker for the electronic gearbox
module electronic_gearbox_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_req,
    input wire logic [gearbox_pkg::RATIO_W-1:0] link_ratio,
    input wire logic [gearbox_pkg::AXIS_W-1:0] link_master,
    input wire logic cancel_req,
    input wire logic fast_halt_request,
    input wire logic axis_override,
    input wire logic [gearbox_pkg::AXIS_W-1:0] override_axis,
    input wire logic [gearbox_pkg::AXIS_W-1:0] base_axis_sel,
    input wire logic rate_wr,
    input wire logic [gearbox_pkg::RATE_W-1:0] rate_wdata,
    input wire logic linked,
    input wire logic [gearbox_pkg::AXIS_W-1:0] master_axis,
    input wire logic [gearbox_pkg::RATIO_W-1:0] target_ratio,
    input wire logic [gearbox_pkg::RATIO_W-1:0] eff_ratio,
    input wire logic [gearbox_pkg::RATE_W-1:0] ratio_slew_rate,
    input wire logic [gearbox_pkg::POS_W-1:0] demand_pos
);
    // --------------------------------------------------------
    // request decode
    // --------------------------------------------------------
    logic addr; // request aimed at the served axis
    logic stop; // addressed cancel or halt
    assign addr = axis_override ? (override_axis == gearbox_pkg::OWN_AXIS)
                                : (base_axis_sel == gearbox_pkg::OWN_AXIS);
    assign stop = (cancel_req || fast_halt_request) && addr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_stop; stop |=> !linked && eff_ratio == 32'h00000000; endproperty
    a_stop: assert property (p_stop) else $error("link not ended");
    property p_no_ramp; stop |=> $stable(demand_pos); endproperty
    a_no_ramp: assert property (p_no_ramp) else $error("demand moved at stop");
    property p_link;
        link_req && addr && !stop && !linked |=>
            linked && target_ratio == $past(link_ratio) && master_axis == $past(link_master);
    endproperty
    a_link: assert property (p_link) else $error("link not made");
    property p_update;
        link_req && addr && !stop && linked && link_master == master_axis |=>
            linked && target_ratio == $past(link_ratio);
    endproperty
    a_update: assert property (p_update) else $error("ratio not updated");
    property p_ignore;
        link_req && linked && link_master != master_axis && !stop |=>
            linked && $stable(target_ratio) && $stable(master_axis);
    endproperty
    a_ignore: assert property (p_ignore) else $error("other master taken");
    property p_other; !addr |=> $stable(target_ratio) && $stable(linked); endproperty
    a_other: assert property (p_other) else $error("other axis acted");
    property p_rate_rst; $fell(rst) |-> ratio_slew_rate == 32'h000F4240; endproperty
    a_rate_rst: assert property (p_rate_rst) else $error("rate reset wrong");
    property p_rate_wr; rate_wr && addr |=> ratio_slew_rate == $past(rate_wdata); endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate not written");
    property p_idle; !linked |=> $stable(demand_pos); endproperty
    a_idle: assert property (p_idle) else $error("demand moved unlinked");
endmodule // electronic_gearbox_chk
bind electronic_gearbox electronic_gearbox_chk chk (.clk, .rst, .link_req, .link_ratio,
    .link_master, .cancel_req, .fast_halt_request, .axis_override, .override_axis,
    .base_axis_sel, .rate_wr, .rate_wdata, .linked, .master_axis, .target_ratio,
    .eff_ratio, .ratio_slew_rate, .demand_pos);

// ===== verification/electronic_gearbox_tb.sv
// self-checking bench for the electronic gearbox
module electronic_gearbox_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, link_req = 1'b0, cancel_req = 1'b0;
    logic fast_halt_request = 1'b0, axis_override = 1'b0, rate_wr = 1'b0;
    logic [1:0] link_master = 2'h0, override_axis = 2'h0, base_axis_sel = 2'h0, master_axis;
    logic [31:0] link_ratio = 32'h0, rate_wdata = 32'h0, target_ratio, eff_ratio;
    logic [31:0] ratio_slew_rate, demand_pos;
    logic [63:0] enc_delta;
    logic linked, servo_tick;
    int num_errors = 0, cmp_count = 0, cycles = 0;
    int last_tick = 0; // cycle count at the previous servo tick
    always #4 clk = ~clk; // 125 MHz
    encoder_model enc (.enc_delta);
    electronic_gearbox dut (.clk, .rst, .link_req, .link_ratio, .link_master, .cancel_req,
        .fast_halt_request, .axis_override, .override_axis, .base_axis_sel, .rate_wr,
        .rate_wdata, .enc_delta, .linked, .master_axis, .target_ratio, .eff_ratio,
        .ratio_slew_rate, .demand_pos, .servo_tick);
    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic link(input logic [31:0] r, input logic [1:0] m);
        link_ratio = r;
        link_master = m;
        link_req = 1'b1;
        @(negedge clk) link_req = 1'b0;
    endtask
    task automatic stop(input logic halt);
        cancel_req = !halt;
        fast_halt_request = halt;
        @(negedge clk) {cancel_req, fast_halt_request} = 2'b00;
    endtask
    // settle a few cycles past the tick so slewed values have landed
    task automatic wait_tick;
        @(posedge servo_tick);
        if (last_tick != 0) begin
            check("tick period", 32'(cycles - last_tick), 32'(gearbox_pkg::TICK_CYCLES));
        end
        last_tick = cycles;
        repeat (4) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard: the run needs about four servo ticks, this allows six
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check("rate", ratio_slew_rate, 32'h000F4240);
        check("demand", demand_pos, 32'h0);
        link(32'h00004000, 2'h1);
        check("linked", 32'(linked), 32'h1);
        check("target", target_ratio, 32'h00004000);
        wait_tick;
        check("eff", eff_ratio, 32'h00004000);
        wait_tick;
        check("demand", demand_pos, 32'h1);
        wait_tick;
        check("demand", demand_pos, 32'h3);
        link(32'hFFFF8000, 2'h2);
        check("master", 32'(master_axis), 32'h1);
        base_axis_sel = 2'h1;
        stop(1'b0);
        check("linked", 32'(linked), 32'h1);
        {base_axis_sel, axis_override, override_axis} = 5'h07;
        link(32'h00000007, 2'h1);
        check("target", target_ratio, 32'h00004000);
        {base_axis_sel, axis_override, override_axis} = 5'h04;
        rate_wdata = 32'h00000010;
        rate_wr = 1'b1;
        @(negedge clk) rate_wr = 1'b0;
        check("rate", ratio_slew_rate, 32'h00000010);
        link(32'hFFFF8000, 2'h1);
        check("target", target_ratio, 32'hFFFF8000);
        wait_tick;
        check("eff", eff_ratio, 32'h00003FCC);
        stop(1'b1);
        check("linked", 32'(linked), 32'h0);
        check("eff", eff_ratio, 32'h0);
        repeat (3) @(negedge clk);
        check("demand", demand_pos, 32'h4);
        link(32'h00010000, 2'h2);
        check("master", 32'(master_axis), 32'h2);
        stop(1'b0);
        check("linked", 32'(linked), 32'h0);
        finish_test();
    end
endmodule // electronic_gearbox_tb
